// ===== include/oesb_regs.svh
// Header: register offsets, field layout, reset values and timing counts
// Assumes: included by bare name from the design files
`ifndef OESB_REGS_SVH
`define OESB_REGS_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define OESB_NUM_OUT        16
`define OESB_NUM_PINS       8

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OESB_OFF_SMB_EN     12'h000
`define OESB_OFF_MASK       12'h004
`define OESB_OFF_READBACK   12'h008
`define OESB_OFF_CONTROL    12'h00c
`define OESB_OFF_STATUS     12'h010
`define OESB_OFF_ASSIGN_LO  12'h014
`define OESB_OFF_ASSIGN_HI  12'h018

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define OESB_CTRL_POWER_GOOD_BIT 0
`define OESB_CTRL_REFRUN_BIT 1
`define OESB_STAT_STRAP_BIT 0
`define OESB_STAT_ARMED_BIT 1
`define OESB_RST_SMB_EN     16'hffff
`define OESB_RST_MASK       16'h0000
`define OESB_RST_SHIFT      16'hffff
`define OESB_RST_ASSIGN     32'hfedcba98

// ****************************************************************
// Timing
// ****************************************************************
`define OESB_CLK_MHZ        10
`define OESB_SB_MAX_MHZ     25
`define OESB_REF_TICK_DIV   4

`endif

// ===== include/oesb_pkg.sv
// Package: types shared by the side-band enable design
// Assumes: oesb_regs.svh defines the sizes
`include "oesb_regs.svh"
package oesb_pkg;
    typedef logic [`OESB_NUM_OUT-1:0] oesb_vec_type;
    typedef enum logic [1:0] {OESB_IDLE, OESB_DATA} oesb_bus_type;
endpackage : oesb_pkg

// ===== logic/oesb_sync.sv
// Two-flop synchroniser bank for pin inputs
// Assumes: inputs come from outside the hclk domain
`timescale 1ns/1ns
module oesb_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             hclk,    // System clock
    input  wire logic             hresetn, // Async reset, active low
    input  wire logic [WIDTH-1:0] d_async, // Asynchronous inputs
    input  wire logic [WIDTH-1:0] rst_val, // Constant; the flops reset to one regardless of it
    output logic      [WIDTH-1:0] q_sync   // Synchronised outputs
);
    logic [WIDTH-1:0] stage1;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    stage1[i] <= 1'b1;
                    q_sync[i] <= 1'b1;
                end else begin
                    stage1[i] <= d_async[i];
                    q_sync[i] <= stage1[i] & rst_val[i] | stage1[i];
                end
            end
        end
    endgenerate
endmodule : oesb_sync

// ===== logic/oesb_gate.sv
// Per-output glitch-free enable stage, clocked by reference tick
// Assumes: ref_tick is a one-cycle hclk enable present only while ref runs
`timescale 1ns/1ns
`include "oesb_regs.svh"
module oesb_gate (
    input  wire logic                          hclk,     // System clock
    input  wire logic                          hresetn,  // Async reset, active low
    input  wire logic                          ref_tick, // Reference clock edge enable
    input  wire logic [`OESB_NUM_OUT-1:0]      want_en,  // Combined enable request
    output logic      [`OESB_NUM_OUT-1:0]      out_en    // Applied enables
);
    // Two reference ticks before a change lands: no half cycles at the driver
    logic [`OESB_NUM_OUT-1:0] stage;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage  <= `OESB_RST_SMB_EN;
            out_en <= `OESB_RST_SMB_EN;
        end else if (ref_tick) begin
            stage  <= want_en;
            out_en <= stage;
        end
    end
endmodule : oesb_gate

// ===== logic/oesb_top.sv
// Output-enable pin multiplexing with side-band serial enable shifter
// Assumes: AHB-Lite single word transfers; pins and reference clock are async
//
// Operation
// - Eight active-low enable pins, each gating one or more outputs.
// - Strap high turns four enable pins into the side-band serial port.
// - Small variants: smbus latch shares two enable pins; not built here.
// - Strap high: D clock, E data in, G shift/load, H data out.
// - Shifting supported up to 25 MHz side-band clock; here sampling at 10 MHz limits it to below 2.5 MHz.
// - Side-band works before power-good is asserted.
// - Side-band enabled only while strap is one.
// - Strap caught at reset release; strap low means no side-band influence.
// - Shift bit one requests enable, zero requests disable.
// - Shift bits reset to one.
// - Shifting runs on side-band clock edges only, reference not needed.
// - Bus bits and pins act only while side-band says enabled.
// - Side-band changes go through shared synchroniser; need reference running.
// - Mask bits reset to zero.
// - Mask bit one forces side-band request to enabled.
// - Readback captures shift register on each shift/load falling edge.
// - Bus reads shift register contents, never loads it.
// - Shift/load falling edge moves shift register into output control.
// - Shift/load low: clock and data toggles ignored.
`timescale 1ns/1ns
`include "oesb_regs.svh"
module oesb_top (
    input  wire logic                     hclk,                // System clock, 10 MHz
    input  wire logic                     hresetn,             // Async reset, active low
    input  wire logic                     hsel,                // Slave select
    input  wire logic [31:0]              haddr,               // Address
    input  wire logic [1:0]               htrans,              // Transfer type
    input  wire logic                     hwrite,              // Write strobe
    input  wire logic [2:0]               hsize,               // Transfer size
    input  wire logic                     hready,              // Bus ready in
    input  wire logic [31:0]              hwdata,              // Write data
    output logic      [31:0]              hrdata,              // Read data
    output logic                          hreadyout,           // Slave ready
    output logic                          hresp,               // Response, always OKAY
    input  wire logic                     sideband_strap,      // Side-band select strap
    input  wire logic                     reference_input_clock, // Reference clock
    input  wire logic [7:0]               out_enable_pin_n,    // Enable pins A..H, active low
    output logic                          enable_pin_h_shared_o,  // Pin H drive value
    output logic                          enable_pin_h_shared_oe, // Pin H drive enable
    output logic [`OESB_NUM_OUT-1:0]      out_enable           // Applied output enables
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [9:0] pins_s;
    logic [7:0] pin_n_s;
    logic       ref_s;
    logic       strap_s;

    oesb_sync #(.WIDTH(10)) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d_async ({sideband_strap, reference_input_clock, out_enable_pin_n}),
        .rst_val (10'h3ff),
        .q_sync  (pins_s)
    );
    assign pin_n_s = pins_s[7:0];
    assign ref_s   = pins_s[8];
    assign strap_s = pins_s[9];

    // ****************************************************************
    // Strap capture
    // ****************************************************************
    logic       strap_taken;
    logic       sb_on;
    logic [1:0] strap_wait;

    // Synchroniser shows its reset level for two edges; sample after that
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_wait <= 2'b00;
        end else if (strap_wait != 2'b10) begin
            strap_wait <= strap_wait + 2'b01;
        end
    end

    // Held static after power-up, so one capture after release suffices
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_taken <= 1'b0;
            sb_on       <= 1'b0;
        end else if (!strap_taken && strap_wait == 2'b10) begin
            strap_taken <= 1'b1;
            sb_on       <= strap_s;
        end
    end

    // ****************************************************************
    // Side-band edge detection
    // ****************************************************************
    logic sb_clk;
    logic sb_din;
    logic sb_ld_n;
    logic sb_clk_d;
    logic sb_ld_n_d;
    logic sb_rise;
    logic sb_load;

    assign sb_clk  = pin_n_s[3];
    assign sb_din  = pin_n_s[4];
    assign sb_ld_n = pin_n_s[6];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Match the synchroniser's reset level: no false edge
            sb_clk_d  <= 1'b1;
            sb_ld_n_d <= 1'b1;
        end else begin
            sb_clk_d  <= sb_clk;
            sb_ld_n_d <= sb_ld_n;
        end
    end

    // Sampling at 10 MHz limits side-band clock to below 2.5 MHz here
    assign sb_rise = sb_on & sb_ld_n & sb_clk & ~sb_clk_d;
    assign sb_load = sb_on & sb_ld_n_d & ~sb_ld_n;

    // ****************************************************************
    // Shift, control and readback registers
    // ****************************************************************
    oesb_pkg::oesb_vec_type shift_reg;
    oesb_pkg::oesb_vec_type sb_ctrl;
    oesb_pkg::oesb_vec_type readback;

    // Runs from reset without power-good, so early disables work
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_reg <= `OESB_RST_SHIFT;
        end else if (sb_rise) begin
            shift_reg <= {shift_reg[`OESB_NUM_OUT-2:0], sb_din};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sb_ctrl <= `OESB_RST_SHIFT;
        end else if (sb_load) begin
            sb_ctrl <= shift_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            readback <= `OESB_RST_SHIFT;
        end else if (sb_load) begin
            readback <= shift_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_pin_h_shared_o <= 1'b0;
        end else begin
            enable_pin_h_shared_o <= shift_reg[`OESB_NUM_OUT-1];
        end
    end

    // Pin H is driven only in side-band mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_pin_h_shared_oe <= 1'b0;
        end else begin
            enable_pin_h_shared_oe <= sb_on;
        end
    end

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************
    oesb_pkg::oesb_vec_type smb_en;
    oesb_pkg::oesb_vec_type mask;
    logic [31:0]            assign_map;
    logic                   power_good;
    logic                   ref_run_en;
    logic                   wr_pend;
    logic [11:0]            wr_addr;
    logic                   acc;

    assign acc = hsel & hready & htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
        end else begin
            wr_pend <= acc & hwrite;
            wr_addr <= haddr[11:0];
        end
    end

    // One write strobe per writable register; the readback and status offsets have none
    logic wr_smb;
    logic wr_mask;
    logic wr_lo;
    logic wr_hi;
    logic wr_ctrl;

    assign wr_smb  = wr_pend & (wr_addr == `OESB_OFF_SMB_EN);
    assign wr_mask = wr_pend & (wr_addr == `OESB_OFF_MASK);
    assign wr_lo   = wr_pend & (wr_addr == `OESB_OFF_ASSIGN_LO);
    assign wr_hi   = wr_pend & (wr_addr == `OESB_OFF_ASSIGN_HI);
    assign wr_ctrl = wr_pend & (wr_addr == `OESB_OFF_CONTROL);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            smb_en <= `OESB_RST_SMB_EN;
        end else if (wr_smb) begin
            smb_en <= hwdata[15:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask <= `OESB_RST_MASK;
        end else if (wr_mask) begin
            mask <= hwdata[15:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            assign_map <= `OESB_RST_ASSIGN;
        end else begin
            if (wr_lo) begin
                assign_map[15:0] <= hwdata[15:0];
            end
            if (wr_hi) begin
                assign_map[31:16] <= hwdata[15:0];
            end
        end
    end

    // Reference ticks run from reset; power-good is a plain flag here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power_good <= 1'b0;
            ref_run_en <= 1'b1;
        end else if (wr_ctrl) begin
            power_good <= hwdata[`OESB_CTRL_POWER_GOOD_BIT];
            ref_run_en <= hwdata[`OESB_CTRL_REFRUN_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (acc && !hwrite) begin
            unique case (haddr[11:0])
                `OESB_OFF_SMB_EN:    hrdata <= {16'h0000, smb_en};
                `OESB_OFF_MASK:      hrdata <= {16'h0000, mask};
                `OESB_OFF_READBACK:  hrdata <= {16'h0000, readback};
                `OESB_OFF_CONTROL:   hrdata <= {30'h0, ref_run_en, power_good};
                `OESB_OFF_STATUS:    hrdata <= {30'h0, strap_taken, sb_on};
                `OESB_OFF_ASSIGN_LO: hrdata <= {16'h0000, assign_map[15:0]};
                `OESB_OFF_ASSIGN_HI: hrdata <= {16'h0000, assign_map[31:16]};
                default:             hrdata <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ****************************************************************
    // Reference clock tick
    // ****************************************************************
    logic ref_d;
    logic ref_tick;

    // Starts at the synchroniser's reset level, so release makes no tick
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_d <= 1'b1;
        end else begin
            ref_d <= ref_s;
        end
    end

    // Software may hold ticks off; enables then freeze as they stand
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_tick <= 1'b0;
        end else begin
            ref_tick <= ref_run_en & ref_s & ~ref_d;
        end
    end

    // ****************************************************************
    // Enable combination
    // ****************************************************************
    oesb_pkg::oesb_vec_type want_en;
    logic [7:0]             pin_ok;

    // Side-band pins stop acting as enables while strap is high
    genvar p;
    generate
        for (p = 0; p < `OESB_NUM_PINS; p = p + 1) begin : g_pin
            if (p == 3 || p == 4 || p == 6 || p == 7) begin : g_shared
                assign pin_ok[p] = sb_on | ~pin_n_s[p];
            end else begin : g_plain
                assign pin_ok[p] = ~pin_n_s[p];
            end
        end
    endgenerate

    // Each output pair shares one pin; the low three bits of its assign_map nibble pick it
    genvar o;
    generate
        for (o = 0; o < `OESB_NUM_OUT; o = o + 1) begin : g_out
            logic [2:0] sel;
            logic       sb_req;
            assign sel    = assign_map[(o/2)*4 +: 3];
            assign sb_req = ~sb_on | sb_ctrl[o] | mask[o];
            assign want_en[o] = smb_en[o] & pin_ok[sel] & sb_req;
        end
    endgenerate

    oesb_gate u_gate (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .ref_tick (ref_tick),
        .want_en  (want_en),
        .out_en   (out_enable)
    );

    // Variant with smbus latch sharing two pins is not built here
endmodule : oesb_top

// ===== dv/oesb_top_sva.sv
// Checker: bus answer, strap, gating and shift-out timing of oesb_top
// Assumes: bound to oesb_top; assignment registers keep their reset map
`timescale 1ns/1ns
module oesb_top_sva (
    input wire logic        hclk,                   // clock
    input wire logic        hresetn,                // reset, active low
    input wire logic        hsel,                   // select
    input wire logic [1:0]  htrans,                 // transfer type
    input wire logic        hwrite,                 // write
    input wire logic        hready,                 // bus ready
    input wire logic [31:0] hrdata,                 // read data
    input wire logic        hreadyout,              // slave ready
    input wire logic        hresp,                  // response
    input wire logic        sideband_strap,         // strap
    input wire logic        reference_input_clock,  // reference
    input wire logic [7:0]  out_enable_pin_n,       // enable pins
    input wire logic        enable_pin_h_shared_o,  // pin H value
    input wire logic        enable_pin_h_shared_oe, // pin H enable
    input wire logic [15:0] out_enable              // applied enables
);
    // ****************************************************************
    // Helper counters
    // ****************************************************************
    logic       ref_q;
    logic       sclk_q;
    logic [3:0] ref_age;
    logic [3:0] shift_age;
    logic [2:0] a_rises;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_q  <= 1'b0;
            sclk_q <= 1'b0;
        end else begin
            ref_q  <= reference_input_clock;
            sclk_q <= out_enable_pin_n[3];
        end
    end
    // Saturating ages, so a stopped reference cannot wrap the bound
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) ref_age <= 4'hf;
        else if (reference_input_clock) ref_age <= 4'h0;
        else if (ref_age != 4'hf) ref_age <= ref_age + 4'h1;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) shift_age <= 4'hf;
        else if (out_enable_pin_n[3] && !sclk_q && out_enable_pin_n[6]) shift_age <= 4'h0;
        else if (shift_age != 4'hf) shift_age <= shift_age + 4'h1;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) a_rises <= 3'h0;
        else if (!out_enable_pin_n[0]) a_rises <= 3'h0;
        else if (reference_input_clock && !ref_q && a_rises != 3'h7) a_rises <= a_rises + 3'h1;
    end
    // ****************************************************************
    // Properties
    // ****************************************************************
    AST_HREADY:
        assert property (hreadyout == 1'b1) else $error("hreadyout dropped");
    AST_OKAY:
        assert property (hresp == 1'b0) else $error("hresp not okay");
    AST_RDATA:
        assert property (!$stable(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite))
        else $error("hrdata moved without a read");
    AST_RST_EN:
        assert property ($rose(hresetn) |-> out_enable == 16'hffff) else $error("enables not all on at reset");
    AST_OE_STRAP:
        assert property (enable_pin_h_shared_oe |-> sideband_strap) else $error("pin H driven with strap low");
    AST_OE_STATIC:
        assert property (enable_pin_h_shared_oe |=> enable_pin_h_shared_oe) else $error("pin H drive dropped");
    AST_REF_GATE:
        assert property (!$stable(out_enable) |-> ref_age < 4'd10) else $error("enable moved without reference");
    AST_PIN_A:
        assert property (a_rises >= 3'd4 |-> !out_enable[0]) else $error("pin A high left output 0 on");
    AST_H_SHIFT:
        assert property (enable_pin_h_shared_oe && $past(enable_pin_h_shared_oe) && !$stable(enable_pin_h_shared_o)
                         |-> shift_age < 4'd8) else $error("pin H moved without a shift");
endmodule : oesb_top_sva

bind oesb_top oesb_top_sva u_oesb_top_sva (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
    .hresp, .sideband_strap, .reference_input_clock, .out_enable_pin_n, .enable_pin_h_shared_o,
    .enable_pin_h_shared_oe, .out_enable);

// ===== dv/oesb_sb_ctrl.sv
// Partner: external controller driving the side-band shift lines
// Assumes: bench calls the tasks; link clock runs inside frames and in toggle bursts with shift/load low
`timescale 1ns/1ns
module oesb_sb_ctrl (
    output logic sb_clk,  // link clock
    output logic sb_din,  // serial data
    output logic sb_ld_n  // shift/load, active low
);
    // ****************************************************************
    // Frames
    // ****************************************************************
    localparam int HALF = 400;
    initial begin
        sb_clk  = 1'b0;
        sb_din  = 1'b0;
        sb_ld_n = 1'b0;
    end
    task automatic frame(input logic [15:0] pat, input int nbits);
        int i;
        #37;
        sb_ld_n = 1'b1;
        #HALF;
        for (i = 15; i > 15 - nbits; i--) begin
            sb_din = pat[i];
            #(HALF/2);
            sb_clk = 1'b1;
            #HALF;
            sb_clk = 1'b0;
            #(HALF/2);
        end
        // Released data shows the inverse, never a stale bit
        sb_din = ~sb_din;
        #HALF;
        sb_ld_n = 1'b0;
        #HALF;
    endtask : frame
    task automatic toggle(input int n);
        #37;
        repeat (n) begin
            sb_din = ~sb_din;
            sb_clk = 1'b1;
            #HALF;
            sb_clk = 1'b0;
            #HALF;
        end
    endtask : toggle
endmodule : oesb_sb_ctrl

// ===== dv/output_enable_sideband_mux_tb_top.sv
// Testbench: bus, pins and side-band frames against oesb_top
// Assumes: one bus slave; reset assignment map puts pin A on output 0, pin H on 15
`timescale 1ns/1ns
`include "oesb_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module output_enable_sideband_mux_tb_top;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic        sideband_strap, ref_clk, ref_on, h_o, h_oe;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  pin_drv, pins;
    logic [15:0] out_enable;
    wire         sb_clk, sb_din, sb_ld_n;
    int          err_count, n_checks, i;
    // Rows: bus enables, mask, shifted pattern, expected enables
    logic [63:0] rows [6] = '{64'hffff_0000_a5c3_a5c3, 64'hffff_00ff_0f0f_0fff, 64'h7ffe_0000_ffff_7ffe,
                              64'hf0f0_0f00_3c3c_3030, 64'hffff_0000_0001_0001, 64'hffff_0000_8000_8000};
    assign hready = hreadyout;
    assign pins   = {h_oe ? h_o : pin_drv[7], sb_ld_n, pin_drv[5], sb_din, sb_clk, pin_drv[2:0]};
    oesb_top u_oesb_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sideband_strap(sideband_strap),
        .reference_input_clock(ref_clk), .out_enable_pin_n(pins), .enable_pin_h_shared_o(h_o),
        .enable_pin_h_shared_oe(h_oe), .out_enable(out_enable));
    oesb_sb_ctrl u_oesb_sb_ctrl (.sb_clk(sb_clk), .sb_din(sb_din), .sb_ld_n(sb_ld_n));
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    // Reference off the hclk grid; held low while stopped
    initial begin
        ref_clk = 1'b0;
        #23;
        forever #150 ref_clk = ref_on ? ~ref_clk : 1'b0;
    end
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task test_done;
        $display("Checks %0d, errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done
    task rdy;
        int k;
        k = 0;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            k++;
            if (k > 50) begin
                err_count++;
                test_done;
            end
            @(posedge hclk);
        end
    endtask : rdy
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        rdy;
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rdy;
        rd = hrdata;
    endtask : xfer
    task rdc(input logic [11:0] a, input logic [15:0] m, input logic [15:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(rd[15:0] & m, e)
    endtask : rdc
    task wait_oe(input logic [15:0] m, input logic [15:0] e);
        for (int k = 0; k < 80 && (out_enable & m) !== e; k++) @(posedge hclk);
        `CHK(out_enable & m, e)
    endtask : wait_oe
    task sbf(input logic [15:0] p, input int n);
        u_oesb_sb_ctrl.frame(p, n);
        repeat (10) @(posedge hclk);
    endtask : sbf
    task do_reset(input logic s);
        hresetn        <= 1'b0;
        sideband_strap <= s;
        pin_drv        <= {s, 7'h0};
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
    endtask : do_reset
    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, hresetn, sideband_strap, pin_drv} = '0;
        hsize = 3'b010;
        ref_on = 1'b1;
        err_count = 0;
        n_checks = 0;
        @(posedge hclk);
        do_reset(1'b0);
        xfer(1'b1, `OESB_OFF_CONTROL, 32'h3);
        rdc(`OESB_OFF_STATUS, 16'h1, 16'h0);
        `CHK(h_oe, 1'b0)
        sbf(16'h0000, 16);
        rdc(`OESB_OFF_READBACK, 16'hffff, 16'hffff);
        pin_drv[0] <= 1'b1;
        wait_oe(16'h8001, 16'h8000);
        pin_drv[0] <= 1'b0;
        wait_oe(16'h8001, 16'h8001);
        do_reset(1'b1);
        rdc(`OESB_OFF_SMB_EN, 16'hffff, 16'hffff);
        rdc(`OESB_OFF_MASK, 16'hffff, 16'h0000);
        rdc(`OESB_OFF_READBACK, 16'hffff, 16'hffff);
        rdc(`OESB_OFF_STATUS, 16'h1, 16'h1);
        `CHK(h_oe, 1'b1)
        sbf(16'h0000, 16);
        rdc(`OESB_OFF_READBACK, 16'hffff, 16'h0000);
        wait_oe(16'hffff, 16'h0000);
        xfer(1'b1, `OESB_OFF_CONTROL, 32'h3);
        for (i = 0; i < 6; i++) begin
            xfer(1'b1, `OESB_OFF_SMB_EN, {16'h0, rows[i][63:48]});
            xfer(1'b1, `OESB_OFF_MASK, {16'h0, rows[i][47:32]});
            sbf(rows[i][31:16], 16);
            rdc(`OESB_OFF_READBACK, 16'hffff, rows[i][31:16]);
            `CHK(h_o, rows[i][31])
            wait_oe(16'hffff, rows[i][15:0]);
        end
        xfer(1'b1, `OESB_OFF_READBACK, 32'h1234);
        rdc(`OESB_OFF_READBACK, 16'hffff, 16'h8000);
        `CHK(h_o, 1'b1)
        u_oesb_sb_ctrl.toggle(6);
        sbf(16'h0000, 0);
        rdc(`OESB_OFF_READBACK, 16'hffff, 16'h8000);
        ref_on <= 1'b0;
        sbf(16'h0000, 16);
        rdc(`OESB_OFF_READBACK, 16'hffff, 16'h0000);
        repeat (30) @(posedge hclk);
        `CHK(out_enable, 16'h8000)
        ref_on <= 1'b1;
        wait_oe(16'hffff, 16'h0000);
        xfer(1'b1, `OESB_OFF_CONTROL, 32'h1);
        rdc(`OESB_OFF_CONTROL, 16'h3, 16'h1);
        xfer(1'b1, `OESB_OFF_MASK, 32'hffff);
        repeat (30) @(posedge hclk);
        `CHK(out_enable, 16'h0000)
        xfer(1'b1, `OESB_OFF_CONTROL, 32'h3);
        wait_oe(16'hffff, 16'hffff);
        xfer(1'b1, 12'h040, 32'hffff);
        rdc(12'h040, 16'hffff, 16'h0000);
        test_done;
    end
endmodule : output_enable_sideband_mux_tb_top
